/* File: rtl/sdc_map.svh */
// Register map, field positions, reset values and timing counts for the
// SYSREF delay and calibration control block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (7-bit serial address)
// ----------------------------------------------------------------------
`define SDC_ADDR_SYSREF_POWER   7'h18
`define SDC_ADDR_SYSREF_DELAY   7'h19
`define SDC_ADDR_FB_DIV_LOW     7'h1a
`define SDC_ADDR_ALIGN_IN_DIV   7'h1b
`define SDC_ADDR_IDENTITY       7'h1c
`define SDC_ADDR_CAL_HIGH       7'h6c
`define SDC_ADDR_CAL_LOW        7'h6d
`define SDC_ADDR_STATUS         7'h6e
`define SDC_ADDR_BIAS_LEVEL     7'h6f
`define SDC_ADDR_CLK_INIT       7'h70
`define SDC_ADDR_DELAY_CAL      7'h71
`define SDC_ADDR_BIAS_CAL       7'h72
`define SDC_ADDR_ALIGN_EDGE     7'h73

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDC_BIT_CMD             7
`define SDC_BIT_BIAS_AC         7
`define SDC_BIT_IDENTITY        4
`define SDC_BIT_ALIGN_PENDING   5
`define SDC_BIT_STARTUP_DONE    1
`define SDC_BIT_READ_EDGE       0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SDC_RST_DELAY_UNIT      2'h0
`define SDC_RST_FB_DIV          9'h010
`define SDC_RST_IN_DIV          7'h08
`define SDC_RST_ALIGN_DIV       1'h0

// ----------------------------------------------------------------------
// Delay step and alignment reference divider
// ----------------------------------------------------------------------
`define SDC_DELAY_UNIT_PS       10'h083
`define SDC_ALIGN_HALF_24       6'h0c
`define SDC_ALIGN_HALF_48       6'h18

// ----------------------------------------------------------------------
// Timing: times in ns, cycle counts derived (least times round up)
// ----------------------------------------------------------------------
`define SDC_CLK_PERIOD_NS       10
`define SDC_STARTUP_NS          20000
`define SDC_CLK_INIT_NS         500
`define SDC_DELAY_CAL_NS        10000
`define SDC_BIAS_CAL_NS         10000
`define SDC_ALIGN_NS            1000
`define SDC_CYCLES(ns) (((ns) + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)

`endif

/* File: rtl/sdc_pkg.sv */
// Types shared by the SYSREF delay and calibration control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sdc_pkg;

  // Oscillator divider settings for the calibration oscillator
  typedef struct packed {
    logic [6:0] input_div;
    logic [8:0] feedback_div;
  } sdc_osc_cfg_s;

  // SYSREF output control towards the analog drivers
  typedef struct packed {
    logic       powerdown;
    logic       bias_ac;
    logic       park_crosspoint;
    logic [1:0] delay_unit_multiplier;
    logic [9:0] step_ps;
  } sdc_sysref_ctl_s;

  typedef enum logic [1:0] {
    SDC_ALIGN_IDLE = 2'b00,
    SDC_ALIGN_WAIT = 2'b01,
    SDC_ALIGN_RUN  = 2'b10
  } sdc_align_e;

endpackage

/* File: rtl/sdc_regs.sv */
// SYSREF delay, calibration and alignment control registers behind a
// 3-wire serial port.
// Assumes serial pins are synchronous to the core clock and toggle well
// below its rate; analog results are stable when their task ends.
//
// Behaviour
// - Delay step is (1 + multiplier) units
// - Steps 131, 262, 393, 524 ps
// - Oscillator feedback divider, resets to 16
// - Oscillator input divider, resets to 8
// - Divide clock by 24 or 48 for alignment
// - Calibration result split, upper bits lower address
// - Calibration command runs calibration, stores result
// - Startup-complete reads 1 only after startup
// - Clock init command initialises dividers and delays
// - Align start sets pending; alignment runs from the next SYSREF rise
// - Pending reads 1 until alignment completes
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_regs
  import sdc_pkg::*;
#(
  parameter logic IDENTITY_BIT = 1'b0,  // Arbitrary value
  parameter int   STARTUP_CYC  = `SDC_CYCLES(`SDC_STARTUP_NS),
  parameter int   INIT_CYC     = `SDC_CYCLES(`SDC_CLK_INIT_NS),
  parameter int   DCAL_CYC     = `SDC_CYCLES(`SDC_DELAY_CAL_NS),
  parameter int   BCAL_CYC     = `SDC_CYCLES(`SDC_BIAS_CAL_NS),
  parameter int   ALIGN_CYC    = `SDC_CYCLES(`SDC_ALIGN_NS)
) (
  // Clock and reset
  input  wire logic      i_core_clk,
  input  wire logic      i_reset_n,
  // Serial port
  input  wire logic      i_spi_sclk,
  input  wire logic      i_spi_cs_n,
  input  wire logic      i_sdio,
  output logic           o_sdio,
  output logic           o_sdio_oe_n,
  // Analog and system side
  input  wire logic      i_sysref_in,
  input  wire logic [14:0] i_cal_measure,
  input  wire logic [5:0]  i_bias_measure,
  output sdc_osc_cfg_s   o_osc_cfg,
  output sdc_sysref_ctl_s o_sysref_ctl,
  output logic           o_clock_init,
  output logic           o_delay_cal_run,
  output logic           o_bias_cal_run,
  output logic           o_align_active,
  output logic           o_align_ref
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic            powerdown,    next_powerdown;
  logic            bias_ac,      next_bias_ac;
  logic            park,         next_park;
  logic [1:0]      dly_mult,     next_dly_mult;
  logic [8:0]      fb_div,       next_fb_div;
  logic [6:0]      in_div,       next_in_div;
  logic            align_div,    next_align_div;
  logic            read_edge,    next_read_edge;
  logic [14:0]     cal_result,   next_cal_result;
  logic [5:0]      bias_level,   next_bias_level;
  logic            init_cmd,     next_init_cmd;
  logic            dcal_cmd,     next_dcal_cmd;
  logic            bcal_cmd,     next_bcal_cmd;
  logic            align_cmd,    next_align_cmd;
  logic            started,      next_started;
  logic            ready,        next_ready;
  logic            sysref_q,     next_sysref_q;
  sdc_align_e      align_st,     next_align_st;
  logic [5:0]      ref_cnt,      next_ref_cnt;
  logic            ref_out,      next_ref_out;
  sdc_sysref_ctl_s ctl_q,        next_ctl;

  // Serial port state
  logic            sclk_q,       next_sclk_q;
  logic [4:0]      bit_cnt,      next_bit_cnt;
  logic [7:0]      shift_in,     next_shift_in;
  logic            is_read,      next_is_read;
  logic [6:0]      addr,         next_addr;
  logic [7:0]      tx,           next_tx;
  logic            sdio_q,       next_sdio_q;
  logic            oe_n_q,       next_oe_n_q;

  // Write strobe from the serial port
  logic            wr_en;
  logic [6:0]      wr_addr;
  logic [7:0]      wr_data;

  // Task handshakes
  logic init_go, init_busy, init_done;
  logic dcal_go, dcal_busy, dcal_done;
  logic bcal_go, bcal_busy, bcal_done;
  logic start_go, start_busy, start_done;
  logic align_go, align_busy, align_done;
  logic sysref_rise;

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_word(input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `SDC_ADDR_SYSREF_POWER: d[`SDC_BIT_CMD] = powerdown;
      `SDC_ADDR_SYSREF_DELAY: d = {bias_ac, dly_mult, 4'h0, fb_div[8]};
      `SDC_ADDR_FB_DIV_LOW:   d = fb_div[7:0];
      `SDC_ADDR_ALIGN_IN_DIV: d = {align_div, in_div};
      `SDC_ADDR_IDENTITY:     d[`SDC_BIT_IDENTITY] = IDENTITY_BIT;
      `SDC_ADDR_CAL_HIGH:     d = {1'b0, cal_result[14:8]};
      `SDC_ADDR_CAL_LOW:      d = cal_result[7:0];
      `SDC_ADDR_STATUS: begin
        d[`SDC_BIT_ALIGN_PENDING] = align_cmd ||
                                    (align_st != SDC_ALIGN_IDLE);
        d[`SDC_BIT_STARTUP_DONE]  = ready;
      end
      `SDC_ADDR_BIAS_LEVEL:   d = {2'h0, bias_level};
      `SDC_ADDR_CLK_INIT:     d[`SDC_BIT_CMD] = init_cmd;
      `SDC_ADDR_DELAY_CAL:    d[`SDC_BIT_CMD] = dcal_cmd;
      `SDC_ADDR_BIAS_CAL:     d[`SDC_BIT_CMD] = bcal_cmd;
      `SDC_ADDR_ALIGN_EDGE: begin
        d[`SDC_BIT_CMD]       = align_cmd;
        d[`SDC_BIT_READ_EDGE] = read_edge;
      end
      default:                d = 8'h00;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Serial port: R/W bit, 7-bit address, data bytes, MSB first
  // ----------------------------------------------------------------------
  // Input bits are taken on rising SCLK; read data leaves on the edge
  // chosen by read_edge. Bursts auto-increment the address.
  always_comb begin
    logic rise;
    logic fall;
    logic out_edge;
    rise          = i_spi_sclk && !sclk_q;
    fall          = !i_spi_sclk && sclk_q;
    out_edge      = read_edge ? rise : fall;
    next_sclk_q   = i_spi_sclk;
    next_bit_cnt  = bit_cnt;
    next_shift_in = shift_in;
    next_is_read  = is_read;
    next_addr     = addr;
    next_tx       = tx;
    next_sdio_q   = sdio_q;
    next_oe_n_q   = oe_n_q;
    wr_en         = 1'b0;
    wr_addr       = addr;
    wr_data       = 8'h00;
    if (i_spi_cs_n) begin
      next_bit_cnt = 5'h00;
      next_oe_n_q  = 1'b1;
    end else begin
      if (out_edge && is_read && bit_cnt[3]) begin
        next_sdio_q = tx[7];
        next_tx     = {tx[6:0], 1'b0};
        next_oe_n_q = 1'b0;
      end
      if (rise) begin
        next_shift_in = {shift_in[6:0], i_sdio};
        next_bit_cnt  = bit_cnt + 5'h01;
        if (bit_cnt == 5'h07) begin
          next_is_read = next_shift_in[7];
          next_addr    = next_shift_in[6:0];
          next_tx      = read_word(next_shift_in[6:0]);
        end else if (bit_cnt == 5'h0f) begin
          wr_en        = !is_read;
          wr_data      = next_shift_in;
          next_addr    = addr + 7'h01;
          next_bit_cnt = 5'h08;
          next_tx      = read_word(addr + 7'h01);
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_q   <= 1'b0;
      bit_cnt  <= 5'h00;
      shift_in <= 8'h00;
      is_read  <= 1'b0;
      addr     <= 7'h00;
      tx       <= 8'h00;
      sdio_q   <= 1'b0;
      oe_n_q   <= 1'b1;
    end else begin
      sclk_q   <= next_sclk_q;
      bit_cnt  <= next_bit_cnt;
      shift_in <= next_shift_in;
      is_read  <= next_is_read;
      addr     <= next_addr;
      tx       <= next_tx;
      sdio_q   <= next_sdio_q;
      oe_n_q   <= next_oe_n_q;
    end
  end

  // ----------------------------------------------------------------------
  // Task launch
  // ----------------------------------------------------------------------
  // A command stays pending while its task is still busy, so a write of 1
  // is never dropped and starts exactly one run.
  assign init_go     = init_cmd && !init_busy;
  assign dcal_go     = dcal_cmd && !dcal_busy;
  assign bcal_go     = bcal_cmd && !bcal_busy;
  assign start_go    = !started;
  assign sysref_rise = i_sysref_in && !sysref_q;
  assign align_go    = (align_st == SDC_ALIGN_WAIT) && sysref_rise;

  sdc_task_timer #(.CYCLES(STARTUP_CYC)) u_startup (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (start_go),
    .o_busy     (start_busy),
    .o_done     (start_done)
  );
  sdc_task_timer #(.CYCLES(INIT_CYC)) u_clk_init (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (init_go),
    .o_busy     (init_busy),
    .o_done     (init_done)
  );
  sdc_task_timer #(.CYCLES(DCAL_CYC)) u_delay_cal (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (dcal_go),
    .o_busy     (dcal_busy),
    .o_done     (dcal_done)
  );
  sdc_task_timer #(.CYCLES(BCAL_CYC)) u_bias_cal (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (bcal_go),
    .o_busy     (bcal_busy),
    .o_done     (bcal_done)
  );
  sdc_task_timer #(.CYCLES(ALIGN_CYC)) u_align (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (align_go),
    .o_busy     (align_busy),
    .o_done     (align_done)
  );

  // ----------------------------------------------------------------------
  // Register and sequencing next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_powerdown  = powerdown;
    next_bias_ac    = bias_ac;
    next_dly_mult   = dly_mult;
    next_fb_div     = fb_div;
    next_in_div     = in_div;
    next_align_div  = align_div;
    next_read_edge  = read_edge;
    next_cal_result = cal_result;
    next_bias_level = bias_level;
    next_sysref_q   = i_sysref_in;
    next_started    = 1'b1;
    next_ready      = ready || start_done;
    // Clear on acceptance first, so a same-cycle write wins
    next_init_cmd   = init_cmd && !init_go;
    next_dcal_cmd   = dcal_cmd && !dcal_go;
    next_bcal_cmd   = bcal_cmd && !bcal_go;
    next_align_cmd  = align_cmd && (align_st != SDC_ALIGN_IDLE);
    next_align_st   = align_st;
    if (wr_en) begin
      case (wr_addr)
        `SDC_ADDR_SYSREF_POWER: next_powerdown = wr_data[`SDC_BIT_CMD];
        `SDC_ADDR_SYSREF_DELAY: begin
          next_bias_ac    = wr_data[`SDC_BIT_BIAS_AC];
          next_dly_mult   = wr_data[6:5];
          next_fb_div[8]  = wr_data[0];
        end
        `SDC_ADDR_FB_DIV_LOW:   next_fb_div[7:0] = wr_data;
        `SDC_ADDR_ALIGN_IN_DIV: begin
          next_align_div = wr_data[7];
          next_in_div    = wr_data[6:0];
        end
        `SDC_ADDR_CLK_INIT:
          next_init_cmd = next_init_cmd || wr_data[`SDC_BIT_CMD];
        `SDC_ADDR_DELAY_CAL:
          next_dcal_cmd = next_dcal_cmd || wr_data[`SDC_BIT_CMD];
        `SDC_ADDR_BIAS_CAL:
          next_bcal_cmd = next_bcal_cmd || wr_data[`SDC_BIT_CMD];
        `SDC_ADDR_ALIGN_EDGE: begin
          next_read_edge = wr_data[`SDC_BIT_READ_EDGE];
          next_align_cmd = next_align_cmd || wr_data[`SDC_BIT_CMD];
        end
        default: ;
      endcase
    end
    if (dcal_done) begin
      next_cal_result = i_cal_measure;
    end
    if (bcal_done) begin
      next_bias_level = i_bias_measure;
    end
    case (align_st)
      SDC_ALIGN_IDLE: begin
        if (align_cmd) begin
          next_align_st  = SDC_ALIGN_WAIT;
        end
      end
      SDC_ALIGN_WAIT: if (align_go) next_align_st = SDC_ALIGN_RUN;
      SDC_ALIGN_RUN:  if (align_done) next_align_st = SDC_ALIGN_IDLE;
      default:        next_align_st = SDC_ALIGN_IDLE;
    endcase
  end

  // Crosspoint parking: armed by a power-down fall in AC mode, released
  // by the first SYSREF rise while powered up or by leaving AC mode, so a halted burst needs the pair again.
  always_comb begin
    next_park = park;
    if (!bias_ac || (sysref_rise && !powerdown)) begin
      next_park = 1'b0;
    end
    if (bias_ac && powerdown && !next_powerdown) begin
      next_park = 1'b1;
    end
    next_ctl.powerdown             = powerdown;
    next_ctl.bias_ac               = bias_ac;
    next_ctl.park_crosspoint       = park;
    next_ctl.delay_unit_multiplier = dly_mult;
    next_ctl.step_ps = 10'(({8'h00, dly_mult} + 10'h001) *
                           `SDC_DELAY_UNIT_PS);
  end

  // Alignment reference: toggles every half ratio of core clocks
  always_comb begin
    logic [5:0] half;
    half         = align_div ? `SDC_ALIGN_HALF_48
                             : `SDC_ALIGN_HALF_24;
    next_ref_cnt = ref_cnt + 6'h01;
    next_ref_out = ref_out;
    if (ref_cnt >= half - 6'h01) begin
      next_ref_cnt = 6'h00;
      next_ref_out = !ref_out;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      powerdown  <= 1'b0;
      bias_ac    <= 1'b0;
      park       <= 1'b0;
      dly_mult   <= `SDC_RST_DELAY_UNIT;
      fb_div     <= `SDC_RST_FB_DIV;
      in_div     <= `SDC_RST_IN_DIV;
      align_div  <= `SDC_RST_ALIGN_DIV;
      read_edge  <= 1'b0;
      cal_result <= 15'h0000;
      bias_level <= 6'h00;
      init_cmd   <= 1'b0;
      dcal_cmd   <= 1'b0;
      bcal_cmd   <= 1'b0;
      align_cmd  <= 1'b0;
      started    <= 1'b0;
      ready      <= 1'b0;
      sysref_q   <= 1'b0;
      align_st   <= SDC_ALIGN_IDLE;
      ref_cnt    <= 6'h00;
      ref_out    <= 1'b0;
      ctl_q      <= '0;
    end else begin
      powerdown  <= next_powerdown;
      bias_ac    <= next_bias_ac;
      park       <= next_park;
      dly_mult   <= next_dly_mult;
      fb_div     <= next_fb_div;
      in_div     <= next_in_div;
      align_div  <= next_align_div;
      read_edge  <= next_read_edge;
      cal_result <= next_cal_result;
      bias_level <= next_bias_level;
      init_cmd   <= next_init_cmd;
      dcal_cmd   <= next_dcal_cmd;
      bcal_cmd   <= next_bcal_cmd;
      align_cmd  <= next_align_cmd;
      started    <= next_started;
      ready      <= next_ready;
      sysref_q   <= next_sysref_q;
      align_st   <= next_align_st;
      ref_cnt    <= next_ref_cnt;
      ref_out    <= next_ref_out;
      ctl_q      <= next_ctl;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_sdio                 = sdio_q;
  assign o_sdio_oe_n            = oe_n_q;
  assign o_osc_cfg.input_div    = in_div;
  assign o_osc_cfg.feedback_div = fb_div;
  assign o_sysref_ctl           = ctl_q;
  assign o_clock_init           = init_busy;
  assign o_delay_cal_run        = dcal_busy;
  assign o_bias_cal_run         = bcal_busy;
  assign o_align_active         = align_busy;
  assign o_align_ref            = ref_out;

endmodule // sdc_regs

/* File: rtl/sdc_task_timer.sv */
// One-shot task timer: a start pulse runs it for CYCLES clocks.
// Assumes start is only honoured while idle.
`timescale 1ns/1ps
module sdc_task_timer #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  // Control
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic        busy;
  logic        next_busy;
  logic        done;
  logic        next_done;

  always_comb begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (busy) begin
      if (count == 16'h0001) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      next_count = count - 16'h0001;
    end else if (i_start) begin
      next_busy  = 1'b1;
      next_count = 16'(CYCLES);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= 16'h0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

  assign o_busy = busy;
  assign o_done = done;

endmodule // sdc_task_timer

/* File: test/sdc_host_model.sv */
// Host controller model driving the 3-wire serial register port.
// Assumes the bench resolves the shared data wire from the device output enable.
`timescale 1ns/1ps
module sdc_host_model (
  // Clock
  input  wire logic i_core_clk,
  // Serial link
  input  wire logic i_sdio,
  output logic      o_spi_sclk,
  output logic      o_spi_cs_n,
  output logic      o_sdio
);
  // Set when read bits leave on rising SCLK: take them at end of high phase
  logic late = 1'b0;
  initial begin
    o_spi_sclk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_sdio     = 1'b0;
  end
  task automatic half();
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    o_spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      // Released wire toggles so a stale bit never reads back as data
      o_sdio = (rd && i < 8) ? ~o_sdio : f[i];
      o_spi_sclk = 1'b0;
      half();
      if (i < 8 && !late) q[i] = i_sdio;
      o_spi_sclk = 1'b1;
      half();
      if (i < 8 && late) q[i] = i_sdio;
    end
    o_spi_cs_n = 1'b1;
    o_spi_sclk = 1'b0;
    half();
  endtask
endmodule // sdc_host_model

/* File: test/sdc_regs_properties.sv */
// Checker for sdc_regs: step value, divider reset, task lengths, park.
// Assumes it is bound to sdc_regs and given its timing parameters.
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_regs_checker
  import sdc_pkg::*;
#(
  parameter int INIT_CYC  = 5,
  parameter int DCAL_CYC  = 10,
  parameter int ALIGN_CYC = 5
) (
  // Clock and reset
  input wire logic            i_core_clk,
  input wire logic            i_reset_n,
  // Watched ports
  input wire logic            i_sysref_in,
  input wire sdc_osc_cfg_s    o_osc_cfg,
  input wire sdc_sysref_ctl_s o_sysref_ctl,
  input wire logic            o_clock_init,
  input wire logic            o_delay_cal_run,
  input wire logic            o_align_active,
  input wire logic            o_align_ref
);
  logic [4:0] cnt;
  logic       last;
  logic       armed;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // ------
  // Half-period counter; first toggle after reset is not judged
  // ------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt   <= 5'h00;
      last  <= 1'b0;
      armed <= 1'b0;
    end else if (o_align_ref != last) begin
      cnt   <= 5'h00;
      last  <= o_align_ref;
      armed <= 1'b1;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
  step_value_a: assert property (
    $past(i_reset_n) |-> o_sysref_ctl.step_ps == `SDC_DELAY_UNIT_PS *
      (10'(o_sysref_ctl.delay_unit_multiplier) + 10'h001))
    else $error("delay step differs from multiplier");
  osc_reset_a: assert property (
    $rose(i_reset_n) |-> o_osc_cfg == {`SDC_RST_IN_DIV, `SDC_RST_FB_DIV})
    else $error("oscillator dividers not at reset value");
  align_ref_a: assert property (
    armed && o_align_ref != last |-> cnt == 5'h0b || cnt == 5'h17)
    else $error("alignment reference half period wrong");
  dcal_len_a: assert property (
    $fell(o_delay_cal_run) |-> $past(o_delay_cal_run, DCAL_CYC) &&
      !$past(o_delay_cal_run, DCAL_CYC + 1))
    else $error("calibration run length wrong");
  init_len_a: assert property (
    $fell(o_clock_init) |-> $past(o_clock_init, INIT_CYC) &&
      !$past(o_clock_init, INIT_CYC + 1))
    else $error("clock init length wrong");
  align_len_a: assert property (
    $fell(o_align_active) |-> $past(o_align_active, ALIGN_CYC) &&
      !$past(o_align_active, ALIGN_CYC + 1))
    else $error("alignment run length wrong");
  align_cause_a: assert property (
    $rose(o_align_active) |-> $past(i_sysref_in) ||
      $past(i_sysref_in, 2) || $past(i_sysref_in, 3))
    else $error("alignment ran without a sysref edge");
  park_cause_a: assert property (
    $rose(o_sysref_ctl.park_crosspoint) |->
      o_sysref_ctl.bias_ac && !o_sysref_ctl.powerdown)
    else $error("outputs parked outside ac bias mode");
  cover property ($fell(o_delay_cal_run));
  cover property ($fell(o_align_active));
  cover property ($rose(o_sysref_ctl.park_crosspoint));
  cover property (armed && o_align_ref != last && cnt == 5'h17);
endmodule // sdc_regs_checker

bind sdc_regs sdc_regs_checker #(
  .INIT_CYC  (INIT_CYC),
  .DCAL_CYC  (DCAL_CYC),
  .ALIGN_CYC (ALIGN_CYC)
) sdc_regs_checker_i (
  .i_core_clk      (i_core_clk),
  .i_reset_n       (i_reset_n),
  .i_sysref_in     (i_sysref_in),
  .o_osc_cfg       (o_osc_cfg),
  .o_sysref_ctl    (o_sysref_ctl),
  .o_clock_init    (o_clock_init),
  .o_delay_cal_run (o_delay_cal_run),
  .o_align_active  (o_align_active),
  .o_align_ref     (o_align_ref)
);

/* File: test/tb_sdc_regs.sv */
// Self-checking bench for sdc_regs through the serial register port.
// Assumes the host model and bound checker are compiled first.
`timescale 1ns/1ps
`include "sdc_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_sdc_regs
  import sdc_pkg::*;
;
  logic            clk = 1'b0;
  logic            rst_n, sclk, cs_n, h_sdio, d_sdio, oe_n, sysref;
  logic            clk_init, dcal, bcal, align_act, align_ref;
  logic [14:0]     cal_meas;
  logic [5:0]      bias_meas;
  logic [7:0]      rd;
  sdc_osc_cfg_s    osc;
  sdc_sysref_ctl_s ctl;
  int              mismatches = 0;
  int              cmp_count = 0;
  wire             sdio = oe_n ? h_sdio : d_sdio;
  always #5 clk = ~clk;
  sdc_host_model sdc_host_model_i (.i_core_clk(clk), .i_sdio(sdio),
    .o_spi_sclk(sclk), .o_spi_cs_n(cs_n), .o_sdio(h_sdio));
  sdc_regs #(.STARTUP_CYC(200), .INIT_CYC(20), .DCAL_CYC(10),
    .BCAL_CYC(10), .ALIGN_CYC(20)) sdc_regs_i (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .i_sdio(sdio), .o_sdio(d_sdio), .o_sdio_oe_n(oe_n),
    .i_sysref_in(sysref), .i_cal_measure(cal_meas),
    .i_bias_measure(bias_meas),
    .o_osc_cfg(osc), .o_sysref_ctl(ctl), .o_clock_init(clk_init),
    .o_delay_cal_run(dcal), .o_bias_cal_run(bcal),
    .o_align_active(align_act), .o_align_ref(align_ref));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    sdc_host_model_i.xfer(1'b0, a, d, rd);
  endtask
  task automatic rdb(input logic [6:0] a);
    sdc_host_model_i.xfer(1'b1, a, 8'h00, rd);
  endtask
  task automatic t_reset();
    `CHK(osc, {`SDC_RST_IN_DIV, `SDC_RST_FB_DIV})
    rdb(`SDC_ADDR_STATUS);
    `CHK(rd, 8'h00)
    rdb(`SDC_ADDR_SYSREF_DELAY);
    `CHK(rd, 8'h00)
    rdb(`SDC_ADDR_ALIGN_IN_DIV);
    `CHK(rd, 8'h08)
    rdb(7'h7f);
    `CHK(rd, 8'h00)
  endtask
  task automatic t_delay();
    for (int m = 0; m < 4; m++) begin
      wr(`SDC_ADDR_SYSREF_DELAY, {1'b0, m[1:0], 5'h00});
      `CHK(ctl.step_ps, 10'(32'h83 * (m + 1)))
    end
    wr(`SDC_ADDR_FB_DIV_LOW, 8'h28);
    wr(`SDC_ADDR_ALIGN_IN_DIV, 8'h84);
    `CHK(osc, {7'h04, 9'h028})
    rdb(`SDC_ADDR_ALIGN_IN_DIV);
    `CHK(rd, 8'h84)
  endtask
  task automatic t_cal();
    cal_meas = 15'h5a3c;
    wr(`SDC_ADDR_DELAY_CAL, 8'h80);
    rdb(`SDC_ADDR_DELAY_CAL);
    `CHK(rd, 8'h00)
    // Result must be the stored copy, not the live measurement
    cal_meas = 15'h7fff;
    wr(`SDC_ADDR_CAL_HIGH, 8'hff);
    rdb(`SDC_ADDR_CAL_HIGH);
    `CHK(rd, 8'h5a)
    rdb(`SDC_ADDR_CAL_LOW);
    `CHK(rd, 8'h3c)
    wr(`SDC_ADDR_BIAS_CAL, 8'h80);
    `CHK(bcal, 1'b1)
    rdb(`SDC_ADDR_BIAS_LEVEL);
    `CHK(rd, 8'h15)
    rdb(`SDC_ADDR_STATUS);
    `CHK(rd, 8'h02)
    wr(`SDC_ADDR_CLK_INIT, 8'h80);
    `CHK(clk_init, 1'b1)
    cyc(25);
    `CHK(clk_init, 1'b0)
  endtask
  task automatic t_align();
    wr(`SDC_ADDR_ALIGN_EDGE, 8'h80);
    rdb(`SDC_ADDR_STATUS);
    `CHK(rd, 8'h22)
    sysref = 1'b1;
    cyc(6);
    `CHK(align_act, 1'b1)
    cyc(30);
    sysref = 1'b0;
    rdb(`SDC_ADDR_STATUS);
    `CHK(rd, 8'h02)
    wr(`SDC_ADDR_ALIGN_EDGE, 8'h01);
    sdc_host_model_i.late = 1'b1;
    rdb(`SDC_ADDR_ALIGN_EDGE);
    `CHK(rd, 8'h01)
    rdb(`SDC_ADDR_CAL_LOW);
    `CHK(rd, 8'h3c)
  endtask
  task automatic t_park();
    wr(`SDC_ADDR_SYSREF_DELAY, 8'h80);
    wr(`SDC_ADDR_SYSREF_POWER, 8'h80);
    wr(`SDC_ADDR_SYSREF_POWER, 8'h00);
    `CHK(ctl.park_crosspoint, 1'b1)
    sysref = 1'b1;
    cyc(4);
    sysref = 1'b0;
    `CHK(ctl.park_crosspoint, 1'b0)
    wr(`SDC_ADDR_SYSREF_POWER, 8'h80);
    wr(`SDC_ADDR_SYSREF_POWER, 8'h00);
    `CHK(ctl.park_crosspoint, 1'b1)
  endtask
  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    sysref = 1'b0;
    cal_meas = 15'h0000;
    bias_meas = 6'h15;
    cyc(6);
    rst_n = 1'b1;
    t_reset();
    t_delay();
    t_cal();
    t_align();
    t_park();
    stop_test();
  end
  // Watchdog against a hung serial frame
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule // tb_sdc_regs
